// ==== pfs_pkg.sv ====
// Purpose: Shared constants for the port pin function select block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Register offsets are byte addresses on the register bus.
package pfs_pkg;

  // Register byte offsets.
  localparam logic [7:0] PFS_OFF_PD_HI_SEL4 = 8'h00;
  localparam logic [7:0] PFS_OFF_PE_LO_SEL4 = 8'h04;
  localparam logic [7:0] PFS_OFF_PB_LO_SEL1 = 8'h08;
  localparam logic [7:0] PFS_OFF_REQ_CTRL = 8'h0c;
  localparam logic [7:0] PFS_OFF_PA_STATE_HI = 8'h10;
  localparam logic [7:0] PFS_OFF_PA_STATE_LO = 8'h14;
  localparam logic [7:0] PFS_OFF_PD_STATE_HI = 8'h18;
  localparam logic [7:0] PFS_OFF_PD_STATE_LO = 8'h1c;

  // Address width used by the decoder.
  localparam int PFS_AW = 8;
  localparam int PFS_RW = 16;

  // Mode field layout.
  localparam int PFS_MODE_W = 3;
  localparam int PFS_D30_LSB = 8;
  localparam int PFS_E15_LSB = 12;
  localparam int PFS_B12_LSB = 0;

  // Mode codes.
  localparam logic [2:0] PFS_MODE_GPIO = 3'h0;
  localparam logic [2:0] PFS_MODE_ALT1 = 3'h1;
  localparam logic [2:0] PFS_MODE_ALT2 = 3'h2;
  localparam logic [2:0] PFS_MODE_REQ = 3'h3;
  localparam logic [2:0] PFS_MODE_ALT4 = 3'h4;

  // Reset values.
  localparam logic [15:0] PFS_RST_SEL = 16'h0000;
  localparam logic [15:0] PFS_RST_PD_HI_EXT = 16'h1111;
  localparam logic [15:0] PFS_RST_REQ_CTRL = 16'h0000;
  localparam logic [15:0] PFS_REQ_CTRL_MASK = 16'h0001;

  // Request control select bit: 0 interrupt request, 1 refresh request.
  localparam int PFS_REQ_SEL_BIT = 0;

  // Pin state positions of the pins whose readout can be blocked.
  localparam int PFS_A8_BIT = 8;
  localparam int PFS_D18_BIT = 2;

  // AXI response codes.
  localparam logic [1:0] PFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] PFS_RESP_DECERR = 2'h3;

  // Write channel states.
  typedef enum logic [1:0] {
    PFS_WR_IDLE = 2'b01,
    PFS_WR_RESP = 2'b10
  } pfs_wr_state_t;

endpackage

// ==== pfs_sync.sv ====
// Purpose: Two flip-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are quasi-static levels; no bus coherence is implied.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/100ps
module pfs_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Data.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1; // First stage, may be metastable.
  logic [WIDTH-1:0] next_stage1; // Next first stage.
  logic [WIDTH-1:0] next_sync_out; // Next second stage.

  // Next values; both stages hold while the enable is low.
  always_comb begin
    next_stage1 = stage1;
    next_sync_out = sync_out;
    if (!aresetn) begin
      next_stage1 = '0;
      next_sync_out = '0;
    end else if (ce) begin
      next_stage1 = async_in;
      next_sync_out = stage1;
    end
  end

  // Register both stages.
  always_ff @(posedge aclk) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule

// ==== pfs_top.sv ====
// Purpose: Pin function select and pin state readout for ports A, B, D, E.
// Assumes: AXI4-Lite slave on aclk; serial status comes from same clock.
// Notes: Pin outputs are registered, so a mode write shows one cycle late.
// Functional notes
// - D30 field bits 10:8, 011 drives request.
// - E15 field bits 14:12, 011 drives request.
// - Control register picks interrupt or refresh output.
// - D select fields reset 000, 001 if external.
// - Port A state registers read live pins.
// - A8 serial, transmit 0, direction 0: unreadable.
// - B12 field bits 2:0 selects its function.
`timescale 1ns/100ps
module pfs_top
  import pfs_pkg::*;
(
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data.
  input wire logic [PFS_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [PFS_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode strap, asynchronous level.
  input wire logic rom_disabled_ext_mode,
  // Live pin levels of ports A and D, asynchronous.
  input wire logic [31:0] port_a_pins,
  input wire logic [31:0] port_d_pins,
  // Serial interface status, same clock.
  input wire logic a8_serial_select,
  input wire logic d18_serial_select,
  input wire logic serial_transmit_enable,
  input wire logic serial_port_direction_bit,
  // Request sources.
  input wire logic interrupt_request_output,
  input wire logic refresh_request_output,
  // General-purpose port drive for the muxed pins.
  input wire logic port_d_pin_30_gpio_out,
  input wire logic port_d_pin_30_gpio_oe,
  input wire logic port_e_pin_15_gpio_out,
  input wire logic port_e_pin_15_gpio_oe,
  input wire logic port_b_pin_12_gpio_out,
  input wire logic port_b_pin_12_gpio_oe,
  // Alternate functions 1, 2, 3, 4 for pin B12.
  input wire logic [3:0] port_b_pin_12_alt_out,
  input wire logic [3:0] port_b_pin_12_alt_oe,
  // Pin drive.
  output logic port_d_pin_30_out,
  output logic port_d_pin_30_oe,
  output logic port_e_pin_15_out,
  output logic port_e_pin_15_oe,
  output logic port_b_pin_12_out,
  output logic port_b_pin_12_oe
);

  // Register offsets that hold a writable word.
  function automatic logic pfs_is_rw(input logic [PFS_AW-1:0] a);
    pfs_is_rw = (a == PFS_OFF_PD_HI_SEL4) || (a == PFS_OFF_PE_LO_SEL4) ||
                (a == PFS_OFF_PB_LO_SEL1) || (a == PFS_OFF_REQ_CTRL);
  endfunction

  // Offsets of the read-only pin state words.
  function automatic logic pfs_is_ro(input logic [PFS_AW-1:0] a);
    pfs_is_ro = (a == PFS_OFF_PA_STATE_HI) || (a == PFS_OFF_PA_STATE_LO) ||
                (a == PFS_OFF_PD_STATE_HI) || (a == PFS_OFF_PD_STATE_LO);
  endfunction

  // Request pin decode shared by D30 and E15; other codes keep GPIO.
  function automatic logic [1:0] pfs_req_pin(
    input logic [2:0] mode,
    input logic use_refresh,
    input logic irq,
    input logic refr,
    input logic gpo,
    input logic gpoe
  );
    if (mode == PFS_MODE_REQ) begin
      pfs_req_pin = {1'b1, use_refresh ? refr : irq};
    end else begin
      pfs_req_pin = {gpoe, gpo};
    end
  endfunction

  // Byte-lane merge of the low 16 bits of a write.
  function automatic logic [15:0] pfs_merge(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] ws
  );
    pfs_merge = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Synchronised pin levels and strap.
  logic [64:0] pins_sync; // Strap, port D, port A.
  logic strap_sync; // Synchronised strap level.
  logic [31:0] pa_sync; // Port A levels.
  logic [31:0] pd_sync; // Port D levels.

  pfs_sync #(.WIDTH(65)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in({rom_disabled_ext_mode, port_d_pins, port_a_pins}),
    .sync_out(pins_sync)
  );

  assign pa_sync = pins_sync[31:0];
  assign pd_sync = pins_sync[63:32];
  assign strap_sync = pins_sync[64];

  // Configuration registers.
  logic [15:0] port_d_high_function_select_4; // D31..D28 mode fields.
  logic [15:0] port_e_low_function_select_4; // E15 mode field and others.
  logic [15:0] port_b_low_function_select_1; // B12 mode field and others.
  logic [15:0] request_output_function_control; // Request source select.
  logic [15:0] next_pd_sel; // Next port D select.
  logic [15:0] next_pe_sel; // Next port E select.
  logic [15:0] next_pb_sel; // Next port B select.
  logic [15:0] next_req_ctrl; // Next request control.
  logic strap_done; // Strap has been applied once.
  logic [1:0] strap_wait; // Lets the synchroniser fill after reset.
  logic next_strap_done; // Next strap flag.
  logic [1:0] next_strap_wait; // Next strap wait count.

  // Write channel state.
  pfs_wr_state_t wr_state; // Idle or answering.
  pfs_wr_state_t next_wr_state; // Next write state.
  logic have_aw; // Write address held.
  logic have_w; // Write data held.
  logic [PFS_AW-1:0] aw_hold; // Held write address.
  logic [31:0] w_hold; // Held write data.
  logic [3:0] ws_hold; // Held strobes.
  logic next_have_aw; // Next address flag.
  logic next_have_w; // Next data flag.
  logic [PFS_AW-1:0] next_aw_hold; // Next held address.
  logic [31:0] next_w_hold; // Next held data.
  logic [3:0] next_ws_hold; // Next held strobes.
  logic [1:0] next_bresp; // Next write response.
  logic do_write; // Both halves present this cycle.

  // Read channel state.
  logic [31:0] next_rdata; // Next read data.
  logic [1:0] next_rresp; // Next read response.
  logic next_rvalid; // Next read valid.
  logic [15:0] rd_word; // Decoded read word.
  logic block_a8; // A8 readout not possible.
  logic block_d18; // D18 readout not possible.

  // Pin drive next values.
  logic [1:0] d30_drive; // Enable and level for D30.
  logic [1:0] e15_drive; // Enable and level for E15.
  logic next_d30_out; // Next D30 level.
  logic next_d30_oe; // Next D30 enable.
  logic next_e15_out; // Next E15 level.
  logic next_e15_oe; // Next E15 enable.
  logic next_b12_out; // Next B12 level.
  logic next_b12_oe; // Next B12 enable.

  // Address and data are accepted once each; a write stalls both channels.
  assign s_axi_awready = !have_aw && (wr_state == PFS_WR_IDLE);
  assign s_axi_wready = !have_w && (wr_state == PFS_WR_IDLE);
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = have_aw && have_w && (wr_state == PFS_WR_IDLE);

  // Write channel and configuration next values.
  always_comb begin
    next_wr_state = wr_state;
    next_have_aw = have_aw;
    next_have_w = have_w;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_ws_hold = ws_hold;
    next_bresp = s_axi_bresp;
    next_pd_sel = port_d_high_function_select_4;
    next_pe_sel = port_e_low_function_select_4;
    next_pb_sel = port_b_low_function_select_1;
    next_req_ctrl = request_output_function_control;
    next_strap_done = strap_done;
    next_strap_wait = strap_wait;
    if (!aresetn) begin
      next_wr_state = PFS_WR_IDLE;
      next_have_aw = 1'b0;
      next_have_w = 1'b0;
      next_aw_hold = '0;
      next_w_hold = '0;
      next_ws_hold = '0;
      next_bresp = PFS_RESP_OKAY;
      next_pd_sel = PFS_RST_SEL;
      next_pe_sel = PFS_RST_SEL;
      next_pb_sel = PFS_RST_SEL;
      next_req_ctrl = PFS_RST_REQ_CTRL;
      next_strap_done = 1'b0;
      next_strap_wait = '0;
    end else if (ce) begin
      // The strap is sampled once the synchroniser holds a real level.
      if (!strap_done) begin
        if (strap_wait != 2'h2) begin
          next_strap_wait = strap_wait + 2'h1;
        end else begin
          next_strap_done = 1'b1;
          if (strap_sync) begin
            next_pd_sel = PFS_RST_PD_HI_EXT;
          end
        end
      end
      if (s_axi_awvalid && s_axi_awready) begin
        next_have_aw = 1'b1;
        next_aw_hold = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_have_w = 1'b1;
        next_w_hold = s_axi_wdata;
        next_ws_hold = s_axi_wstrb;
      end
      case (wr_state)
        PFS_WR_IDLE: begin
          if (do_write) begin
            next_have_aw = 1'b0;
            next_have_w = 1'b0;
            next_wr_state = PFS_WR_RESP;
            next_bresp = PFS_RESP_OKAY;
            // Select fields take effect on the pins one cycle later.
            case (aw_hold)
              PFS_OFF_PD_HI_SEL4: begin
                next_pd_sel = pfs_merge(next_pd_sel, w_hold, ws_hold);
              end
              PFS_OFF_PE_LO_SEL4: begin
                next_pe_sel = pfs_merge(next_pe_sel, w_hold, ws_hold);
              end
              PFS_OFF_PB_LO_SEL1: begin
                next_pb_sel = pfs_merge(next_pb_sel, w_hold, ws_hold);
              end
              PFS_OFF_REQ_CTRL: begin
                next_req_ctrl = pfs_merge(next_req_ctrl, w_hold, ws_hold) &
                                PFS_REQ_CTRL_MASK;
              end
              default: begin
                // Pin state words ignore writes; others are unmapped.
                next_bresp = pfs_is_ro(aw_hold) ? PFS_RESP_SLVERR :
                             PFS_RESP_DECERR;
              end
            endcase
          end
        end
        PFS_WR_RESP: begin
          if (s_axi_bready) begin
            next_wr_state = PFS_WR_IDLE;
          end
        end
        default: begin
          next_wr_state = PFS_WR_IDLE;
        end
      endcase
    end
  end

  // Register the write channel and configuration.
  always_ff @(posedge aclk) begin
    wr_state <= next_wr_state;
    have_aw <= next_have_aw;
    have_w <= next_have_w;
    aw_hold <= next_aw_hold;
    w_hold <= next_w_hold;
    ws_hold <= next_ws_hold;
    s_axi_bresp <= next_bresp;
    port_d_high_function_select_4 <= next_pd_sel;
    port_e_low_function_select_4 <= next_pe_sel;
    port_b_low_function_select_1 <= next_pb_sel;
    request_output_function_control <= next_req_ctrl;
    strap_done <= next_strap_done;
    strap_wait <= next_strap_wait;
  end

  assign s_axi_bvalid = (wr_state == PFS_WR_RESP);

  // Serial pins with transmit and port direction both off cannot be read.
  assign block_a8 = a8_serial_select && !serial_transmit_enable &&
                    !serial_port_direction_bit;
  assign block_d18 = d18_serial_select && !serial_transmit_enable &&
                     !serial_port_direction_bit;

  // Read word decode; blocked pins read as zero.
  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      PFS_OFF_PD_HI_SEL4: rd_word = port_d_high_function_select_4;
      PFS_OFF_PE_LO_SEL4: rd_word = port_e_low_function_select_4;
      PFS_OFF_PB_LO_SEL1: rd_word = port_b_low_function_select_1;
      PFS_OFF_REQ_CTRL: rd_word = request_output_function_control;
      PFS_OFF_PA_STATE_HI: rd_word = pa_sync[31:16];
      PFS_OFF_PA_STATE_LO: begin
        rd_word = pa_sync[15:0];
        if (block_a8) begin
          rd_word[PFS_A8_BIT] = 1'b0;
        end
      end
      PFS_OFF_PD_STATE_HI: begin
        rd_word = pd_sync[31:16];
        if (block_d18) begin
          rd_word[PFS_D18_BIT] = 1'b0;
        end
      end
      PFS_OFF_PD_STATE_LO: rd_word = pd_sync[15:0];
      default: rd_word = '0;
    endcase
  end

  // Read channel next values; one answer outstanding at a time.
  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (!aresetn) begin
      next_rdata = '0;
      next_rresp = PFS_RESP_OKAY;
      next_rvalid = 1'b0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        next_rvalid = 1'b1;
        next_rdata = {16'h0000, rd_word};
        next_rresp = (pfs_is_rw(s_axi_araddr) || pfs_is_ro(s_axi_araddr)) ?
                     PFS_RESP_OKAY : PFS_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        next_rvalid = 1'b0;
      end
    end
  end

  // Register the read channel.
  always_ff @(posedge aclk) begin
    s_axi_rdata <= next_rdata;
    s_axi_rresp <= next_rresp;
    s_axi_rvalid <= next_rvalid;
  end

  // Pin function mux for the two request-capable pins.
  assign d30_drive = pfs_req_pin(
    port_d_high_function_select_4[PFS_D30_LSB +: PFS_MODE_W],
    request_output_function_control[PFS_REQ_SEL_BIT],
    interrupt_request_output, refresh_request_output,
    port_d_pin_30_gpio_out, port_d_pin_30_gpio_oe);
  assign e15_drive = pfs_req_pin(
    port_e_low_function_select_4[PFS_E15_LSB +: PFS_MODE_W],
    request_output_function_control[PFS_REQ_SEL_BIT],
    interrupt_request_output, refresh_request_output,
    port_e_pin_15_gpio_out, port_e_pin_15_gpio_oe);

  // Pin drive next values, including the B12 alternate functions.
  always_comb begin
    next_d30_out = port_d_pin_30_out;
    next_d30_oe = port_d_pin_30_oe;
    next_e15_out = port_e_pin_15_out;
    next_e15_oe = port_e_pin_15_oe;
    next_b12_out = port_b_pin_12_out;
    next_b12_oe = port_b_pin_12_oe;
    if (!aresetn) begin
      next_d30_out = 1'b0;
      next_d30_oe = 1'b0;
      next_e15_out = 1'b0;
      next_e15_oe = 1'b0;
      next_b12_out = 1'b0;
      next_b12_oe = 1'b0;
    end else if (ce) begin
      {next_d30_oe, next_d30_out} = d30_drive;
      {next_e15_oe, next_e15_out} = e15_drive;
      case (port_b_low_function_select_1[PFS_B12_LSB +: PFS_MODE_W])
        PFS_MODE_ALT1: begin
          next_b12_out = port_b_pin_12_alt_out[0];
          next_b12_oe = port_b_pin_12_alt_oe[0];
        end
        PFS_MODE_ALT2: begin
          next_b12_out = port_b_pin_12_alt_out[1];
          next_b12_oe = port_b_pin_12_alt_oe[1];
        end
        PFS_MODE_REQ: begin
          next_b12_out = port_b_pin_12_alt_out[2];
          next_b12_oe = port_b_pin_12_alt_oe[2];
        end
        PFS_MODE_ALT4: begin
          next_b12_out = port_b_pin_12_alt_out[3];
          next_b12_oe = port_b_pin_12_alt_oe[3];
        end
        default: begin
          // Unused codes keep the general-purpose port on the pin.
          next_b12_out = port_b_pin_12_gpio_out;
          next_b12_oe = port_b_pin_12_gpio_oe;
        end
      endcase
    end
  end

  // Register the pin drive so the pins see no decode glitches.
  always_ff @(posedge aclk) begin
    port_d_pin_30_out <= next_d30_out;
    port_d_pin_30_oe <= next_d30_oe;
    port_e_pin_15_out <= next_e15_out;
    port_e_pin_15_oe <= next_e15_oe;
    port_b_pin_12_out <= next_b12_out;
    port_b_pin_12_oe <= next_b12_oe;
  end

endmodule

// ==== pfs_monitor.sv ====
// Purpose: Protocol and pin mux checks on the pin function select block.
// Assumes: Writes offer address and data together, with full strobes.
// Notes: Mode shadows update at the response handshake, one edge late.
`timescale 1ns/100ps
module pfs_monitor
  import pfs_pkg::*;
(
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // Register bus.
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Pin sources.
  input logic interrupt_request_output,
  input logic refresh_request_output,
  input logic port_d_pin_30_gpio_out,
  input logic port_d_pin_30_gpio_oe,
  input logic [3:0] port_b_pin_12_alt_out,
  // Pin drive.
  input logic port_d_pin_30_out,
  input logic port_d_pin_30_oe,
  input logic port_b_pin_12_out
);
  logic [7:0] wa; // Last accepted write address.
  logic [15:0] wd; // Last accepted write data.
  logic [2:0] d30; // Shadow of the D30 mode field.
  logic [2:0] b12; // Shadow of the B12 mode field.
  logic usr; // Shadow of the request select bit.
  logic [3:0] aq; // Alternate outputs one cycle back.

  // Shadows lag the design by one edge, which matches the registered pins.
  always_ff @(posedge aclk) begin
    aq <= port_b_pin_12_alt_out;
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[15:0];
    if (!aresetn) begin
      d30 <= 3'h0;
      b12 <= 3'h0;
      usr <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0) begin
      if (wa == 8'h00) d30 <= wd[10:8];
      if (wa == 8'h08) b12 <= wd[2:0];
      if (wa == 8'h0c) usr <= wd[0];
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_wr_ans;
    s_wr_take |=> s_b_late;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_d30;
    d30 == 3'h3 |-> port_d_pin_30_oe && port_d_pin_30_out ==
      (usr ? $past(refresh_request_output) : $past(interrupt_request_output));
  endproperty
  property p_d30_gpio;
    $past(aresetn) && d30 != 3'h3 |-> port_d_pin_30_oe ==
      $past(port_d_pin_30_gpio_oe) &&
      port_d_pin_30_out == $past(port_d_pin_30_gpio_out);
  endproperty
  property p_b12;
    b12 >= 3'h1 && b12 <= 3'h4 |-> port_b_pin_12_out == aq[b12 - 3'h1];
  endproperty

  a_wr_ans: assert property (p_wr_ans) else $error("late write response");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_rd_ans: assert property (p_rd_ans) else $error("late read answer");
  a_ar_busy: assert property (p_ar_busy) else $error("read accepted busy");
  a_d30: assert property (p_d30) else $error("d30 req wrong");
  a_d30_gpio: assert property (p_d30_gpio) else $error("d30 gpio");
  a_b12: assert property (p_b12) else $error("b12 function wrong");
endmodule
bind pfs_top pfs_monitor mon (.*);

// ==== testbench.sv ====
// Purpose: Register and pin tests for the pin function select block.
// Assumes: One clock; request sources held at fixed levels.
// Notes: Pins are sampled two edges after the last mode write response of each setting.
`timescale 1ns/100ps
module testbench;
  import pfs_pkg::*;
  logic aclk, aresetn, ce, rom_disabled_ext_mode;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, port_a_pins, port_d_pins;
  logic [3:0] s_axi_wstrb, port_b_pin_12_alt_out, port_b_pin_12_alt_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp, ex;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, slow;
  logic a8_serial_select, d18_serial_select;
  logic serial_transmit_enable, serial_port_direction_bit;
  logic interrupt_request_output, refresh_request_output;
  logic port_d_pin_30_gpio_out, port_d_pin_30_gpio_oe;
  logic port_e_pin_15_gpio_out, port_e_pin_15_gpio_oe;
  logic port_b_pin_12_gpio_out, port_b_pin_12_gpio_oe;
  logic port_d_pin_30_out, port_d_pin_30_oe, port_e_pin_15_out;
  logic port_e_pin_15_oe, port_b_pin_12_out, port_b_pin_12_oe;
  logic [3:0] oh; // One-hot alternate pattern for B12.
  int fails, samples_checked;

  pfs_top dut (.*);

  // Free-running 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Prints the verdict and stops.
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One write; with slow set, bready is held back for a few cycles.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 4) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
    s_axi_bready <= 1'b0;
    if (n >= 60) begin
      fails++;
      final_report();
    end
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  // One read, compared with the expected data and response.
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 4) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
    s_axi_rready <= 1'b0;
    if (n >= 60) begin
      fails++;
      final_report();
    end
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  // Reset held four cycles, then time for the strap to settle.
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask

  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, slow, rom_disabled_ext_mode} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    {port_a_pins, port_d_pins} = 64'h0;
    {a8_serial_select, d18_serial_select} = 2'h0;
    {serial_transmit_enable, serial_port_direction_bit} = 2'h0;
    interrupt_request_output = 1'b1;
    refresh_request_output = 1'b0;
    {port_d_pin_30_gpio_out, port_d_pin_30_gpio_oe} = 2'h0;
    {port_e_pin_15_gpio_out, port_e_pin_15_gpio_oe} = 2'h0;
    {port_b_pin_12_gpio_out, port_b_pin_12_gpio_oe} = 2'h1;
    {port_b_pin_12_alt_out, port_b_pin_12_alt_oe} = 8'h0;
    fails = 0;
    samples_checked = 0;
    do_reset();
    for (int i = 0; i < 4; i++) rdc(8'(i * 4), 32'h0, 2'h0);
    // Only the select bit of the control register is kept.
    wr(8'h0c, 32'hffff_ffff, 2'h0);
    rdc(8'h0c, 32'h1, 2'h0);
    // Every code on D30 and E15, with each request source selected.
    for (int c = 0; c < 8; c++) begin
      for (int u = 0; u < 2; u++) begin
        port_d_pin_30_gpio_out <= c[0];
        port_d_pin_30_gpio_oe <= c[1];
        port_e_pin_15_gpio_out <= c[0];
        port_e_pin_15_gpio_oe <= c[1];
        wr(8'h0c, 32'(u), 2'h0);
        wr(8'h00, 32'(c) << 8, 2'h0);
        wr(8'h04, 32'(c) << 12, 2'h0);
        repeat (2) @(posedge aclk);
        ex = (c == 3) ? {u == 0, 1'b1} : {c[0], c[1]};
        check("d30", {port_d_pin_30_out, port_d_pin_30_oe}, ex);
        check("e15", {port_e_pin_15_out, port_e_pin_15_oe}, ex);
      end
      rdc(8'h00, 32'(c) << 8, 2'h0);
      rdc(8'h04, 32'(c) << 12, 2'h0);
    end
    // Every code on B12; a wrong alternate index shows as a low output.
    for (int c = 0; c < 8; c++) begin
      oh = (c >= 1 && c <= 4) ? 4'h1 << (c - 1) : 4'hf;
      port_b_pin_12_alt_out <= oh;
      port_b_pin_12_alt_oe <= ~oh;
      wr(8'h08, 32'(c), 2'h0);
      repeat (2) @(posedge aclk);
      ex = (c >= 1 && c <= 4) ? 2'b10 : 2'b01;
      check("b12", {port_b_pin_12_out, port_b_pin_12_oe}, ex);
      rdc(8'h08, 32'(c), 2'h0);
    end
    // Live pin readout, blocked only for serial select with both bits low.
    port_a_pins <= 32'ha5c3_1f96;
    port_d_pins <= 32'h5a3c_e169;
    for (int k = 0; k < 8; k++) begin
      a8_serial_select <= k[2];
      d18_serial_select <= k[2];
      serial_transmit_enable <= k[1];
      serial_port_direction_bit <= k[0];
      repeat (6) @(posedge aclk);
      rdc(8'h10, 32'h0000_a5c3, 2'h0);
      rdc(8'h14, (k == 4) ? 32'h1e96 : 32'h1f96, 2'h0);
      rdc(8'h18, (k == 4) ? 32'h5a38 : 32'h5a3c, 2'h0);
      rdc(8'h1c, 32'h0000_e169, 2'h0);
    end
    // Stalled answers, a write to a read-only place and an unmapped one.
    slow = 1'b1;
    wr(8'h14, 32'h0000_ffff, 2'h2);
    rdc(8'h14, 32'h1f96, 2'h0);
    slow = 1'b0;
    wr(8'h20, 32'h1, 2'h3);
    rdc(8'h20, 32'h0, 2'h3);
    // Strap high across a reset loads the external-mode value.
    rom_disabled_ext_mode <= 1'b1;
    do_reset();
    rdc(8'h00, 32'h1111, 2'h0);
    rdc(8'h04, 32'h0, 2'h0);
    final_report();
  end
endmodule
